// *** hdl/pts_cfg.svh ***
// Register map, field positions, encodings and reset values of the sequencer
`ifndef PTS_CFG_SVH
`define PTS_CFG_SVH
`define PTS_A_CST 4'h0
`define PTS_A_CON 4'h1
`define PTS_A_SDLIM 4'h2
`define PTS_A_C0LIM 4'h3
`define PTS_A_C1LIM 4'h4
`define PTS_A_T0LIM 4'h5
`define PTS_A_T1LIM 4'h6
`define PTS_A_BTE 4'h7
`define PTS_A_QUE_BIT 3
`define PTS_B_ON 15
`define PTS_B_IDLE 13
`define PTS_B_TOGL 12
`define PTS_B_SWT 10
`define PTS_B_SSEN 9
`define PTS_B_VIS 8
`define PTS_B_RUN 7
`define PTS_B_WDTO 6
`define PTS_F_ITM 1:0
`define PTS_F_CLK 15:13
`define PTS_F_DIV 12:8
`define PTS_F_PWD 7:4
`define PTS_F_WDT 2:0
`define PTS_CST_WMASK 16'hB383
`define PTS_CON_WMASK 16'hFFF7
`define PTS_RST16 16'h0000
`define PTS_OP_CTRL 4'h0
`define PTS_OP_WHI 4'h1
`define PTS_OP_WLO 4'h2
`define PTS_OP_TRIG 4'h3
`define PTS_OP_IRQ 4'h4
`define PTS_OP_JMP 4'h5
`define PTS_CT_SWT 4'h1
`define PTS_CT_TMR0 4'h2
`define PTS_CT_TMR1 4'h3
`define PTS_CT_BCAST 4'hF
`define PTS_CK_PER 3'h0
`define PTS_CK_OSC 3'h1
`define PTS_CK_CONV 3'h2
`define PTS_CK_T1 3'h3
`define PTS_CK_T2 3'h4
`define PTS_CK_T3 3'h5
`define PTS_WDT_OFF 3'h0
`define PTS_WDT_BASE 10'h008
`endif

// *** hdl/pts_pkg.sv ***
// Types shared by the trigger sequencer
package pts_pkg;
   typedef enum logic [2:0] {
      ST_FETCH, ST_EXEC, ST_WAIT_IN, ST_WAIT_SW, ST_WAIT_TMR, ST_DELAY
   } pts_state_t;
endpackage

// *** hdl/pts_top.sv ***
// Peripheral trigger sequencer: registers, step engine and trigger outputs
//
// Behaviour
// - Unit runs only while module_on set
// - idle_halt freezes the unit in Idle
// - Toggle mode inverts addressed trigger output
// - Otherwise trigger step emits one pulse
// - Writing one triggers; writing zero does nothing
// - single_step_on enables single-step mode
// - Single-step raises interrupt per step
// - live_count_view reads show live counters
// - Otherwise limit reads return written limits
// - sequence_run executes queue continuously; clear stops
// - Watchdog expiry sets sticky watchdog_expired
// - Watchdog expiry raises an interrupt
// - input_wait_mode picks edge/level, delay or not
// - That mode affects only input waits
// - clock_source_sel picks the sequencer clock
// - Prescaler divides by field plus one
// - Pulses last pulse_width_sel plus one ticks
// - Watchdog off at 000, else 8..512
// - Software supplies eight-bit step commands
// - Two 16-bit timers, two 16-bit counters
// - Waits detect rising or falling edges
// - Four interrupts raised by step commands
// - Limits and broadcast locked while running
//
// Added by the designer: the register offsets and the address-and-strobe port.
`include "pts_cfg.svh"
`timescale 1ns/1ns
`default_nettype none
module pts_top
   import pts_pkg::*;
(
   // Clock and reset
   input wire logic clk_sys,
   input wire logic rst_n,
   // Register port
   input wire logic [3:0] reg_addr,
   input wire logic [15:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [15:0] reg_rdata,
   // Device state
   input wire logic idle_mode,
   // Clock source ticks, one-cycle enables
   input wire logic osc_tick,
   input wire logic converter_conv_clock,
   input wire logic timer_one_clock,
   input wire logic timer_two_clock,
   input wire logic timer_three_clock,
   // Peripheral triggers
   input wire logic [15:0] trig_in,
   output logic [15:0] trigger_output,
   output logic [15:0] bcast_out,
   // Processor interrupt pulses
   output logic [3:0] irq_user,
   output logic irq_step,
   output logic irq_watchdog
);

   logic [15:0] cst_reg;
   logic [15:0] con_reg;
   logic [15:0] sdlim_reg;
   logic [15:0] bte_reg;
   logic [15:0] clim_reg [2];
   logic [15:0] tlim_reg [2];
   logic [7:0] queue_reg [8];
   logic soft_pend_reg;
   logic wdto_reg;
   logic [4:0] div_reg;
   logic [15:0] in_s1_reg;
   logic [15:0] in_s2_reg;
   logic [15:0] in_s3_reg;
   pts_state_t state_reg;
   logic [2:0] ptr_reg;
   logic [7:0] cmd_reg;
   logic [15:0] delay_reg;
   logic [15:0] tmr_reg [2];
   logic [15:0] loop_reg [2];
   logic [9:0] wdt_reg;
   logic [3:0] pulse_reg;
   logic [15:0] pulse_mask_reg;
   logic [15:0] toggle_reg;

   function automatic logic [9:0] wdt_last(input logic [2:0] sel);
      wdt_last = (`PTS_WDT_BASE << (sel - 3'h1)) - 10'h001;
   endfunction

   function automatic logic is_lim_addr(input logic [3:0] a);
      is_lim_addr = (a >= `PTS_A_SDLIM) && (a <= `PTS_A_BTE);
   endfunction

   wire module_on = cst_reg[`PTS_B_ON];
   wire idle_halt = cst_reg[`PTS_B_IDLE];
   wire output_toggle_mode = cst_reg[`PTS_B_TOGL];
   wire single_step_on = cst_reg[`PTS_B_SSEN];
   wire live_count_view = cst_reg[`PTS_B_VIS];
   wire sequence_run = cst_reg[`PTS_B_RUN];
   wire [1:0] input_wait_mode = cst_reg[`PTS_F_ITM];
   wire [2:0] clock_source_sel = con_reg[`PTS_F_CLK];
   wire [4:0] clock_prescale = con_reg[`PTS_F_DIV];
   wire [3:0] pulse_width_sel = con_reg[`PTS_F_PWD];
   wire [2:0] watchdog_period_sel = con_reg[`PTS_F_WDT];

   wire halted = idle_halt & idle_mode;
   wire active = module_on & ~halted;
   wire step_go = active & sequence_run;
   wire locked = module_on & sequence_run;
   wire wr_cst = reg_wr && reg_addr == `PTS_A_CST;
   wire wr_lim = reg_wr & ~locked & is_lim_addr(reg_addr);

   // Clock source selection; reserved codes stop the sequencer clock
   logic src_tick;
   always_comb begin
      unique case (clock_source_sel)
         `PTS_CK_PER: src_tick = 1'b1;
         `PTS_CK_OSC: src_tick = osc_tick;
         `PTS_CK_CONV: src_tick = converter_conv_clock;
         `PTS_CK_T1: src_tick = timer_one_clock;
         `PTS_CK_T2: src_tick = timer_two_clock;
         `PTS_CK_T3: src_tick = timer_three_clock;
         default: src_tick = 1'b0;
      endcase
   end

   wire seq_tick = active & src_tick & (div_reg == clock_prescale);

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         div_reg <= 5'h00;
      end else if (!module_on) begin
         div_reg <= 5'h00;
      end else if (active & src_tick) begin
         div_reg <= (div_reg == clock_prescale) ? 5'h00 : div_reg + 5'h01;
      end
   end

   // Two-stage synchroniser, third stage only for edge history
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         in_s1_reg <= 16'h0000;
         in_s2_reg <= 16'h0000;
         in_s3_reg <= 16'h0000;
      end else begin
         in_s1_reg <= trig_in;
         in_s2_reg <= in_s1_reg;
         in_s3_reg <= in_s2_reg;
      end
   end

   // Command decode
   wire [3:0] op = cmd_reg[7:4];
   wire [3:0] opt = cmd_reg[3:0];
   wire tsel = cmd_reg[0];
   wire lsel = cmd_reg[3];
   wire in_now = in_s2_reg[opt];
   wire in_old = in_s3_reg[opt];
   wire want_high = (op == `PTS_OP_WHI);
   logic in_hit;
   always_comb begin
      if (input_wait_mode[1]) begin
         in_hit = want_high ? in_now : ~in_now;
      end else begin
         in_hit = want_high ? (in_now & ~in_old) : (~in_now & in_old);
      end
   end
   wire wdt_on = watchdog_period_sel != `PTS_WDT_OFF;
   wire wdt_fire = (state_reg == ST_WAIT_IN) & step_go & seq_tick & wdt_on
                   & (wdt_reg == wdt_last(watchdog_period_sel));
   wire tmr_hit = seq_tick & (tmr_reg[tsel] == tlim_reg[tsel]);
   wire loop_more = loop_reg[lsel] != clim_reg[lsel];
   // Skipping the delay is an input-wait property only
   wire skip_delay = input_wait_mode[0];
   wire no_delay = (sdlim_reg == 16'h0000);

   logic cmd_done;
   logic want_delay;
   always_comb begin
      cmd_done = 1'b0;
      want_delay = ~no_delay;
      unique case (state_reg)
         ST_EXEC: begin
            unique case (op)
               `PTS_OP_WHI, `PTS_OP_WLO: cmd_done = 1'b0;
               `PTS_OP_CTRL: cmd_done = (opt != `PTS_CT_SWT)
                  && (opt != `PTS_CT_TMR0) && (opt != `PTS_CT_TMR1);
               `PTS_OP_JMP: cmd_done = ~loop_more;
               default: cmd_done = 1'b1;
            endcase
         end
         ST_WAIT_IN: begin
            cmd_done = in_hit | wdt_fire;
            want_delay = ~no_delay & ~skip_delay;
         end
         ST_WAIT_SW: cmd_done = soft_pend_reg;
         ST_WAIT_TMR: cmd_done = tmr_hit;
         ST_FETCH, ST_DELAY: cmd_done = 1'b0;
      endcase
   end
   wire finish = step_go & cmd_done;

   // Step engine
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         state_reg <= ST_FETCH;
         ptr_reg <= 3'h0;
         cmd_reg <= 8'h00;
      end else if (!module_on) begin
         state_reg <= ST_FETCH;
         ptr_reg <= 3'h0;
      end else if (step_go) begin
         unique case (state_reg)
            ST_FETCH: begin
               cmd_reg <= queue_reg[ptr_reg];
               state_reg <= ST_EXEC;
            end
            ST_EXEC: begin
               if (op == `PTS_OP_WHI || op == `PTS_OP_WLO) begin
                  state_reg <= ST_WAIT_IN;
               end else if (op == `PTS_OP_CTRL && opt == `PTS_CT_SWT) begin
                  state_reg <= ST_WAIT_SW;
               end else if (op == `PTS_OP_CTRL && (opt == `PTS_CT_TMR0
                            || opt == `PTS_CT_TMR1)) begin
                  state_reg <= ST_WAIT_TMR;
               end else if (op == `PTS_OP_JMP && loop_more) begin
                  ptr_reg <= cmd_reg[2:0];
                  state_reg <= ST_FETCH;
               end
            end
            ST_DELAY: begin
               if (delay_reg == sdlim_reg) begin
                  state_reg <= ST_FETCH;
               end
            end
            ST_WAIT_IN, ST_WAIT_SW, ST_WAIT_TMR: ;
         endcase
         if (finish) begin
            ptr_reg <= ptr_reg + 3'h1;
            state_reg <= want_delay ? ST_DELAY : ST_FETCH;
         end
      end
   end

   // Step delay and watchdog counters
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         delay_reg <= 16'h0000;
         wdt_reg <= 10'h000;
      end else begin
         if (state_reg != ST_DELAY || !module_on) begin
            delay_reg <= 16'h0000;
         end else if (step_go & seq_tick) begin
            delay_reg <= delay_reg + 16'h0001;
         end
         if (state_reg != ST_WAIT_IN || !module_on || finish) begin
            wdt_reg <= 10'h000;
         end else if (step_go & seq_tick) begin
            wdt_reg <= wdt_reg + 10'h001;
         end
      end
   end

   // General purpose timers and loop counters
   genvar gi;
   generate
      for (gi = 0; gi < 2; gi++) begin : g_cnt
         always_ff @(posedge clk_sys or negedge rst_n) begin
            if (!rst_n) begin
               tmr_reg[gi] <= 16'h0000;
               loop_reg[gi] <= 16'h0000;
            end else if (!module_on) begin
               tmr_reg[gi] <= 16'h0000;
               loop_reg[gi] <= 16'h0000;
            end else begin
               if (step_go && state_reg == ST_WAIT_TMR && tsel == gi
                   && seq_tick) begin
                  tmr_reg[gi] <= tmr_hit ? 16'h0000 : tmr_reg[gi] + 16'h0001;
               end
               if (step_go && state_reg == ST_EXEC && op == `PTS_OP_JMP
                   && lsel == gi) begin
                  loop_reg[gi] <= loop_more ? loop_reg[gi] + 16'h0001 : 16'h0000;
               end
            end
         end
      end
   endgenerate

   // Trigger outputs
   wire exec_go = step_go && state_reg == ST_EXEC;
   wire trig_go = exec_go && op == `PTS_OP_TRIG;
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         toggle_reg <= 16'h0000;
         pulse_mask_reg <= 16'h0000;
         pulse_reg <= 4'h0;
      end else if (!module_on) begin
         toggle_reg <= 16'h0000;
         pulse_mask_reg <= 16'h0000;
         pulse_reg <= 4'h0;
      end else if (trig_go && output_toggle_mode) begin
         toggle_reg[opt] <= ~toggle_reg[opt];
      end else if (trig_go) begin
         // A new pulse restarts the shared width count
         pulse_mask_reg[opt] <= 1'b1;
         pulse_reg <= 4'h0;
      end else if (seq_tick && pulse_mask_reg != 16'h0000) begin
         if (pulse_reg == pulse_width_sel) begin
            pulse_mask_reg <= 16'h0000;
            pulse_reg <= 4'h0;
         end else begin
            pulse_reg <= pulse_reg + 4'h1;
         end
      end
   end
   assign trigger_output = toggle_reg | pulse_mask_reg;

   // Broadcast and interrupt pulses
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         bcast_out <= 16'h0000;
         irq_user <= 4'h0;
         irq_step <= 1'b0;
         irq_watchdog <= 1'b0;
      end else begin
         bcast_out <= (exec_go && op == `PTS_OP_CTRL
                       && opt == `PTS_CT_BCAST) ? bte_reg : 16'h0000;
         irq_user <= 4'h0;
         if (exec_go && op == `PTS_OP_IRQ) begin
            irq_user[opt[1:0]] <= 1'b1;
         end
         irq_step <= finish & single_step_on;
         irq_watchdog <= wdt_fire;
      end
   end

   // Control, status and configuration registers
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         cst_reg <= `PTS_RST16;
         con_reg <= `PTS_RST16;
         soft_pend_reg <= 1'b0;
         wdto_reg <= 1'b0;
      end else begin
         if (wr_cst) begin
            cst_reg <= reg_wdata & `PTS_CST_WMASK;
         end
         if (reg_wr && reg_addr == `PTS_A_CON) begin
            con_reg <= reg_wdata & `PTS_CON_WMASK;
         end
         // Set wins over a clear in the same cycle
         if (wr_cst && reg_wdata[`PTS_B_SWT]) begin
            soft_pend_reg <= 1'b1;
         end else if (finish && state_reg == ST_WAIT_SW) begin
            soft_pend_reg <= 1'b0;
         end
         if (wdt_fire) begin
            wdto_reg <= 1'b1;
         end else if (wr_cst && !reg_wdata[`PTS_B_WDTO]) begin
            wdto_reg <= 1'b0;
         end
      end
   end

   // Limit, broadcast and queue registers
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         sdlim_reg <= `PTS_RST16;
         bte_reg <= `PTS_RST16;
         clim_reg <= '{default: `PTS_RST16};
         tlim_reg <= '{default: `PTS_RST16};
         queue_reg <= '{default: 8'h00};
      end else if (reg_wr && reg_addr[`PTS_A_QUE_BIT]) begin
         queue_reg[reg_addr[2:0]] <= reg_wdata[7:0];
      end else if (wr_lim) begin
         unique case (reg_addr)
            `PTS_A_SDLIM: sdlim_reg <= reg_wdata;
            `PTS_A_C0LIM: clim_reg[0] <= reg_wdata;
            `PTS_A_C1LIM: clim_reg[1] <= reg_wdata;
            `PTS_A_T0LIM: tlim_reg[0] <= reg_wdata;
            `PTS_A_T1LIM: tlim_reg[1] <= reg_wdata;
            default: bte_reg <= reg_wdata;
         endcase
      end
   end

   // Read path, data valid the cycle after the strobe
   logic [15:0] rd_next;
   always_comb begin
      rd_next = 16'h0000;
      if (reg_addr[`PTS_A_QUE_BIT]) begin
         rd_next = {8'h00, queue_reg[reg_addr[2:0]]};
      end else begin
         unique case (reg_addr)
            `PTS_A_CST: begin
               rd_next = cst_reg;
               rd_next[`PTS_B_SWT] = soft_pend_reg;
               rd_next[`PTS_B_WDTO] = wdto_reg;
            end
            `PTS_A_CON: rd_next = con_reg;
            `PTS_A_SDLIM: rd_next = live_count_view ? delay_reg : sdlim_reg;
            `PTS_A_C0LIM: rd_next = live_count_view ? loop_reg[0] : clim_reg[0];
            `PTS_A_C1LIM: rd_next = live_count_view ? loop_reg[1] : clim_reg[1];
            `PTS_A_T0LIM: rd_next = live_count_view ? tmr_reg[0] : tlim_reg[0];
            `PTS_A_T1LIM: rd_next = live_count_view ? tmr_reg[1] : tlim_reg[1];
            default: rd_next = bte_reg;
         endcase
      end
   end

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         reg_rdata <= 16'h0000;
      end else begin
         reg_rdata <= reg_rd ? rd_next : 16'h0000;
      end
   end

endmodule // pts_top
`default_nettype wire

// *** verif/pts_top_properties.sv ***
// Port-level checks for the trigger sequencer
`include "pts_cfg.svh"
`timescale 1ns/1ns
`default_nettype none
module pts_top_properties (
   // Clock and reset
   input wire logic clk_sys,
   input wire logic rst_n,
   // Register port
   input wire logic [3:0] reg_addr,
   input wire logic [15:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [15:0] reg_rdata,
   // Device state and outputs
   input wire logic idle_mode,
   input wire logic [15:0] trigger_output,
   input wire logic [3:0] irq_user,
   input wire logic irq_step,
   input wire logic irq_watchdog
);
   logic [15:0] cst_q;
   logic [15:0] con_q;
   logic [9:0] hi_cnt;
   logic plain;
   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (!rst_n);
   // Shadows of what software wrote; hardware-set bits are left out
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         cst_q <= 16'h0000;
         con_q <= 16'h0000;
      end else if (reg_wr && reg_addr == `PTS_A_CST) begin
         cst_q <= reg_wdata & `PTS_CST_WMASK;
      end else if (reg_wr && reg_addr == `PTS_A_CON) begin
         con_q <= reg_wdata & `PTS_CON_WMASK;
      end
   end
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         hi_cnt <= 10'h000;
      end else begin
         hi_cnt <= trigger_output[3] ? hi_cnt + 10'h001 : 10'h000;
      end
   end
   // Width is exact only on the undivided system clock in pulse mode
   assign plain = cst_q[15] && cst_q[7] && !cst_q[12] &&
      con_q[15:8] == 8'h00 && !(cst_q[13] && idle_mode);
   sequence off_held;
      (!cst_q[15]) [*3];
   endsequence
   sequence halted;
      (cst_q[15] && cst_q[13] && idle_mode) [*3];
   endsequence
   rd_quiet_a:
      assert property (!$past(reg_rd) |-> reg_rdata == 16'h0000)
      else $error("read data driven outside a read answer");
   cfg_read_a:
      assert property (reg_rd && reg_addr == `PTS_A_CON |=>
         reg_rdata == $past(con_q))
      else $error("clock config read differs from written value");
   ctl_read_a:
      assert property (reg_rd && reg_addr == `PTS_A_CST |=>
         (reg_rdata & 16'hFBBF) == $past(cst_q))
      else $error("control read differs from written value");
   pulse_len_a:
      assert property ($fell(trigger_output[3]) && plain |->
         hi_cnt == {6'h00, con_q[7:4]} + 10'h001)
      else $error("trigger pulse width wrong");
   off_quiet_a:
      assert property (off_held |-> trigger_output == 16'h0000 &&
         irq_user == 4'h0 && !irq_step && !irq_watchdog)
      else $error("outputs active while disabled");
   halt_still_a:
      assert property (halted |-> $stable(trigger_output) && !irq_step)
      else $error("sequencer moved while halted in idle");
   step_irq_a:
      assert property (irq_step |-> $past(cst_q[9]) ##1 !irq_step)
      else $error("step interrupt without single step");
   wdog_irq_a:
      assert property (irq_watchdog |->
         ($past(con_q) & 16'h0007) != 16'h0000 ##1 !irq_watchdog)
      else $error("watchdog interrupt while watchdog off");
   user_irq_a:
      assert property (irq_user != 4'h0 |->
         $onehot(irq_user) ##1 irq_user == 4'h0)
      else $error("user interrupt not a single pulse");
endmodule // pts_top_properties
bind pts_top pts_top_properties pts_top_properties_i (.clk_sys, .rst_n,
   .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .idle_mode,
   .trigger_output, .irq_user, .irq_step, .irq_watchdog);
`default_nettype wire

// *** verif/pts_periph_model.sv ***
// Peripheral side: trigger levels and clock source ticks
`timescale 1ns/1ns
`default_nettype none
module pts_periph_model #(
   parameter int TICK_P = 5
) (
   // Clock and reset
   input wire logic clk_sys,
   input wire logic rst_n,
   // Levels requested by the bench
   input wire logic [15:0] lvl,
   // Towards the sequencer
   output logic [15:0] trig_in,
   output logic osc_tick,
   output logic converter_conv_clock,
   output logic timer_one_clock,
   output logic timer_two_clock,
   output logic timer_three_clock
);
   int cnt;
   // Sources tick at one rate but in different phases
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         cnt <= 0;
         trig_in <= 16'h0000;
         osc_tick <= 1'b0;
         converter_conv_clock <= 1'b0;
         timer_one_clock <= 1'b0;
         timer_two_clock <= 1'b0;
         timer_three_clock <= 1'b0;
      end else begin
         cnt <= cnt == TICK_P - 1 ? 0 : cnt + 1;
         trig_in <= lvl;
         osc_tick <= cnt == 0;
         converter_conv_clock <= cnt == 1;
         timer_one_clock <= cnt == 2;
         timer_two_clock <= cnt == 3;
         timer_three_clock <= cnt == 4;
      end
   end
endmodule // pts_periph_model
`default_nettype wire

// *** verif/tb_pts_top.sv ***
// Self-checking bench for the trigger sequencer
`include "pts_cfg.svh"
`timescale 1ns/1ns
`default_nettype none
module tb_pts_top;
   logic clk_sys, rst_n, reg_wr, reg_rd, idle_mode, irq_step, irq_watchdog;
   logic osc_tick, converter_conv_clock, timer_one_clock;
   logic timer_two_clock, timer_three_clock;
   logic [3:0] reg_addr;
   logic [3:0] irq_user;
   logic [15:0] reg_wdata, reg_rdata, lvl, trig_in, trigger_output, bcast_out;
   int err_total = 0;
   int checked = 0;
   int cyc = 0;
   pts_top pts_top_i (.clk_sys, .rst_n, .reg_addr, .reg_wdata, .reg_wr,
      .reg_rd, .reg_rdata, .idle_mode, .osc_tick, .converter_conv_clock,
      .timer_one_clock, .timer_two_clock, .timer_three_clock, .trig_in,
      .trigger_output, .bcast_out, .irq_user, .irq_step, .irq_watchdog);
   pts_periph_model pts_periph_model_i (.clk_sys, .rst_n, .lvl, .trig_in,
      .osc_tick, .converter_conv_clock, .timer_one_clock, .timer_two_clock,
      .timer_three_clock);
   initial begin
      clk_sys = 1'b0;
      forever #4 clk_sys = ~clk_sys;
   end
   task automatic end_sim();
      if (err_total == 0 && checked > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask
   // Longest run is the watchdog sweep, a few thousand cycles
   always @(posedge clk_sys) begin
      cyc++;
      if (cyc == 20000) begin
         err_total++;
         end_sim();
      end
   end
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      checked++;
      if (got !== exp) begin
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
         err_total++;
      end
   endtask
   task automatic wr(input logic [3:0] a, input logic [15:0] d);
      @(posedge clk_sys);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge clk_sys);
      reg_wr <= 1'b0;
   endtask
   task automatic rd(input logic [3:0] a, input logic [15:0] e);
      @(posedge clk_sys);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge clk_sys);
      reg_rd <= 1'b0;
      @(negedge clk_sys);
      chk(reg_rdata, e);
   endtask
   // Disabling first restarts the pointer at queue byte 0
   task automatic go(input logic [7:0] q0, input logic [7:0] q1,
      input logic [15:0] con, input logic [15:0] cst);
      wr(`PTS_A_CST, 16'h0000);
      for (int i = 0; i < 8; i++) begin
         wr(4'(8 + i), {8'h00, i == 0 ? q0 : i == 1 ? q1 : 8'h00});
      end
      wr(`PTS_A_CON, con);
      wr(`PTS_A_CST, cst);
   endtask
   task automatic gl(input logic [7:0] q0, input logic [7:0] q1,
      input logic [3:0] a, input logic [15:0] v, input logic [15:0] cst);
      go(q0, q1, 16'h0000, 16'h0000);
      wr(a, v);
      wr(`PTS_A_CST, cst);
   endtask
   task automatic pw(input int b, output int w);
      int n;
      n = 0;
      w = 0;
      while (trigger_output[b] !== 1'b1 && n < 60) begin
         @(negedge clk_sys);
         n++;
      end
      while (trigger_output[b] === 1'b1 && w < 80) begin
         @(negedge clk_sys);
         w++;
      end
   endtask
   task automatic ev(input int s, input int n, output int c, output int f);
      logic v;
      c = 0;
      f = -1;
      repeat (2) @(negedge clk_sys);
      for (int i = 3; i <= n; i++) begin
         @(negedge clk_sys);
         v = s < 4 ? irq_user[s] : s == 4 ? irq_step : irq_watchdog;
         if (v === 1'b1) begin
            f = f < 0 ? i : f;
            c++;
         end
      end
   endtask
   task automatic t_regs();
      rd(`PTS_A_CST, 16'h0000);
      rd(`PTS_A_CON, 16'h0000);
      wr(`PTS_A_CON, 16'hFFFF);
      rd(`PTS_A_CON, 16'hFFF7);
      wr(`PTS_A_CST, 16'h4B00);
      rd(`PTS_A_CST, 16'h0300);
      wr(`PTS_A_SDLIM, 16'h1234);
      rd(`PTS_A_SDLIM, 16'h0000);
      wr(`PTS_A_CST, 16'h0000);
      rd(`PTS_A_SDLIM, 16'h1234);
      wr(`PTS_A_SDLIM, 16'h0000);
      go(8'h00, 8'h00, 16'h0000, 16'h8080);
      wr(`PTS_A_C0LIM, 16'h5555);
      wr(`PTS_A_CST, 16'h0000);
      rd(`PTS_A_C0LIM, 16'h0000);
      wr(`PTS_A_C0LIM, 16'h5555);
      rd(`PTS_A_C0LIM, 16'h5555);
   endtask
   task automatic t_pulse();
      int w;
      go(8'h33, 8'h00, 16'h0030, 16'h8080);
      pw(3, w);
      chk(16'(w), 16'h0004);
      wr(`PTS_A_CST, 16'h8000);
      pw(3, w);
      chk(16'(w), 16'h0000);
      go(8'h33, 8'h00, 16'h0030, 16'h0080);
      pw(3, w);
      chk(16'(w), 16'h0000);
      go(8'h35, 8'h00, 16'h0000, 16'h9080);
      pw(5, w);
      chk(16'(w > 8 && w < 60), 16'h0001);
      for (int s = 1; s < 6; s++) begin
         go(8'h33, 8'h00, {3'(s), 13'h0010}, 16'h8080);
         pw(3, w);
         chk(16'(w >= 6 && w <= 10), 16'h0001);
      end
      go(8'h33, 8'h00, 16'h0310, 16'h8080);
      pw(3, w);
      chk(16'(w >= 5 && w <= 8), 16'h0001);
   endtask
   task automatic t_mode();
      int w;
      @(posedge clk_sys);
      idle_mode <= 1'b1;
      go(8'h33, 8'h00, 16'h0000, 16'hA080);
      pw(3, w);
      chk(16'(w), 16'h0000);
      wr(`PTS_A_CST, 16'h8080);
      pw(3, w);
      chk(16'(w), 16'h0001);
      @(posedge clk_sys);
      idle_mode <= 1'b0;
      go(8'h01, 8'h36, 16'h0000, 16'h8080);
      pw(6, w);
      chk(16'(w), 16'h0000);
      wr(`PTS_A_CST, 16'h8480);
      pw(6, w);
      chk(16'(w), 16'h0001);
   endtask
   task automatic t_irq();
      int c, f;
      go(8'h00, 8'h00, 16'h0000, 16'h8280);
      ev(4, 20, c, f);
      chk(16'(c >= 1), 16'h0001);
      wr(`PTS_A_CST, 16'h8080);
      ev(4, 20, c, f);
      chk(16'(c), 16'h0000);
      for (int k = 0; k < 4; k++) begin
         go(8'h40 | 8'(k), 8'h00, 16'h0000, 16'h8080);
         ev(k, 12, c, f);
         chk(16'(c), 16'h0001);
      end
      // Input held low keeps the wait open until the watchdog ends it
      for (int k = 1; k < 8; k++) begin
         go(8'h12, 8'h00, 16'(k), 16'h8080);
         ev(5, 600, c, f);
         chk(16'(f >= (4 << k) && f <= (4 << k) + 8), 16'h0001);
      end
      rd(`PTS_A_CST, 16'h80C0);
      go(8'h12, 8'h00, 16'h0000, 16'h8080);
      ev(5, 40, c, f);
      chk(16'(c), 16'h0000);
   endtask
   task automatic t_wait();
      int w;
      go(8'h12, 8'h33, 16'h0000, 16'h8081);
      pw(3, w);
      chk(16'(w), 16'h0000);
      @(posedge clk_sys);
      lvl <= 16'h0004;
      pw(3, w);
      chk(16'(w), 16'h0001);
      pw(3, w);
      chk(16'(w), 16'h0000);
      go(8'h12, 8'h33, 16'h0000, 16'h8083);
      pw(3, w);
      chk(16'(w), 16'h0001);
      go(8'h22, 8'h33, 16'h0000, 16'h8080);
      @(posedge clk_sys);
      lvl <= 16'h0000;
      pw(3, w);
      chk(16'(w), 16'h0001);
   endtask
   task automatic t_cnt();
      int c, f;
      gl(8'h0F, 8'h00, `PTS_A_BTE, 16'hA5C3, 16'h8080);
      repeat (3) @(negedge clk_sys);
      chk(bcast_out, 16'hA5C3);
      gl(8'h02, 8'h40, `PTS_A_T0LIM, 16'h0014, 16'h8080);
      ev(0, 40, c, f);
      chk(16'(c == 1 && f >= 20 && f <= 28), 16'h0001);
      gl(8'h40, 8'h50, `PTS_A_C0LIM, 16'h0002, 16'h8080);
      ev(0, 20, c, f);
      chk(16'(c), 16'h0003);
      gl(8'h2A, 8'h40, `PTS_A_SDLIM, 16'h0008, 16'h8082);
      ev(0, 30, c, f);
      chk(16'(f >= 13), 16'h0001);
      gl(8'h2A, 8'h40, `PTS_A_SDLIM, 16'h0008, 16'h8083);
      ev(0, 12, c, f);
      chk(16'(f > 0 && f <= 8), 16'h0001);
      gl(8'h40, 8'h40, `PTS_A_SDLIM, 16'h0008, 16'h8083);
      ev(0, 12, c, f);
      chk(16'(c), 16'h0001);
   endtask
   initial begin
      rst_n = 1'b0;
      reg_addr = 4'h0;
      reg_wdata = 16'h0000;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      idle_mode = 1'b0;
      lvl = 16'h0000;
      repeat (6) @(posedge clk_sys);
      rst_n <= 1'b1;
      t_regs();
      t_pulse();
      t_mode();
      t_irq();
      t_wait();
      t_cnt();
      end_sim();
   end
endmodule // tb_pts_top
`default_nettype wire
